// >>> core/sacs_map.svh
// Timing counts and code constants for the conversion sequencer
`ifndef SACS_MAP_SVH
`define SACS_MAP_SVH

`define SACS_CLK_PERIOD_NS 10
`define SACS_MAX_RATE_SPS 250000
`define SACS_MIN_CYCLE_NS (1000000000 / `SACS_MAX_RATE_SPS)
`define SACS_MIN_CYCLE_CYC (`SACS_MIN_CYCLE_NS / `SACS_CLK_PERIOD_NS)
`define SACS_TICK_NS 50
`define SACS_TICK_CYC \
  ((`SACS_TICK_NS + `SACS_CLK_PERIOD_NS - 1) / `SACS_CLK_PERIOD_NS)
`define SACS_TICK_CNT_W 3
`define SACS_ACQ_NS 1800
`define SACS_ACQ_CYC \
  ((`SACS_ACQ_NS + `SACS_CLK_PERIOD_NS - 1) / `SACS_CLK_PERIOD_NS)
`define SACS_ACQ_CNT_W 8
`define SACS_NUM_BITS 16
`define SACS_MSB_INDEX 15
`define SACS_CODE_ZERO 16'h0000
`define SACS_CODE_MID 16'h8000
`define SACS_CODE_FULL 16'hFFFF

`endif

// >>> core/sacs_pkg.sv
// Types shared by the conversion sequencer files
package sacs_pkg;

  typedef enum logic [4:0] {
    ST_ACQUIRE = 5'h01,
    ST_OPEN_SW = 5'h02,
    ST_GROUND = 5'h04,
    ST_TRIAL = 5'h08,
    ST_FINISH = 5'h10
  } sacs_state_t;

  typedef struct packed {
    logic pos_comparator_ground_switch;
    logic neg_comparator_ground_switch;
    logic arrays_to_inputs;
    logic [15:0] element_to_ref;
  } sacs_dac_ctrl_t;

  typedef struct packed {
    logic busy;
    logic acquiring;
    logic core_powered;
    logic done;
  } sacs_status_t;

endpackage

// >>> core/sacs_conv_clock.sv
// On-chip conversion clock: one tick per trial interval while running
`timescale 1ns/100ps
`default_nettype none
`include "sacs_map.svh"

module sacs_conv_clock
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  output logic tick
);

  logic [`SACS_TICK_CNT_W-1:0] cnt_r;
  logic [`SACS_TICK_CNT_W-1:0] cnt_nxt;
  logic wrap;

  assign wrap = (cnt_r == `SACS_TICK_CNT_W'(`SACS_TICK_CYC - 1));
  assign tick = run && wrap;

  always_comb
  begin
    cnt_nxt = cnt_r;
    if (!run || wrap)
    begin
      cnt_nxt = '0;
    end
    else
    begin
      cnt_nxt = cnt_r + `SACS_TICK_CNT_W'(1);
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cnt_r <= '0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
    end
  end

endmodule
`default_nettype wire

// >>> core/sacs_sequencer.sv
// Successive-approximation conversion sequencer for a 16-bit charge DAC
// Function
// [RULE1] Strobe rise after acquisition starts conversion
// [RULE2] Acquisition: comparator grounded, arrays on inputs
// [RULE3] Open ground switches first, then arrays grounded
// [RULE4] Sixteen binary-weighted trials, MSB first
// [RULE5] Result reflects input held at acquisition end
// [RULE6] After last trial: power down, acquire, done
// [RULE7] Internal conversion clock times trials, no shift clock
// [RULE8] Output code is 16-bit straight binary
// [RULE9] Overrange saturates at all ones
// [RULE10] Underrange saturates at all zeros
// [RULE11] Result belongs to same conversion, no latency
// [RULE12] Up to 250 kSPS, powered down between
// [RULE13] Started conversion ignores later strobe changes
// [RULE14] Set trial bit, keep or clear by comparator
`timescale 1ns/100ps
`default_nettype none
`include "sacs_map.svh"

module sacs_sequencer
(
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic CONVERT_STROBE,
  input wire logic COMP_KEEP,
  output sacs_pkg::sacs_dac_ctrl_t DAC_CTRL,
  output sacs_pkg::sacs_status_t STATUS,
  output logic [15:0] RESULT
);

  function automatic logic [15:0] bit_mask(input logic [3:0] idx);
    bit_mask = 16'h0001 << idx;
  endfunction

  sacs_pkg::sacs_state_t state_r;
  sacs_pkg::sacs_state_t state_nxt;
  logic [3:0] idx_r;
  logic [3:0] idx_nxt;
  logic [15:0] sar_r;
  logic [15:0] sar_nxt;
  logic [15:0] result_r;
  logic [15:0] result_nxt;
  logic [`SACS_ACQ_CNT_W-1:0] acq_cnt_r;
  logic [`SACS_ACQ_CNT_W-1:0] acq_cnt_nxt;
  logic gnd_closed_r;
  logic gnd_closed_nxt;
  logic to_inputs_r;
  logic to_inputs_nxt;
  logic power_r;
  logic power_nxt;
  logic done_r;
  logic done_nxt;
  logic strobe_d_r;
  logic strobe_rise;
  logic acq_complete;
  logic clk_run;
  logic tick;

  assign strobe_rise = CONVERT_STROBE && !strobe_d_r;
  assign acq_complete =
    (acq_cnt_r == `SACS_ACQ_CNT_W'(`SACS_ACQ_CYC));
  assign clk_run = (state_r == sacs_pkg::ST_OPEN_SW) ||
                   (state_r == sacs_pkg::ST_GROUND) ||
                   (state_r == sacs_pkg::ST_TRIAL);

  sacs_conv_clock u_conv_clock
  (
    .clk(CLK_SYS),
    .rst_n(RST_N),
    .run(clk_run),
    .tick(tick) // RULE7
  );

  // Conversion sequence
  always_comb
  begin
    state_nxt = state_r;
    idx_nxt = idx_r;
    sar_nxt = sar_r;
    result_nxt = result_r;
    acq_cnt_nxt = acq_cnt_r;
    gnd_closed_nxt = gnd_closed_r;
    to_inputs_nxt = to_inputs_r;
    power_nxt = power_r;
    done_nxt = 1'b0;
    case (state_r)
      sacs_pkg::ST_ACQUIRE:
      begin
        if (!acq_complete)
        begin
          acq_cnt_nxt = acq_cnt_r + `SACS_ACQ_CNT_W'(1); // RULE12
        end
        gnd_closed_nxt = 1'b1; // RULE2
        to_inputs_nxt = 1'b1; // RULE2
        sar_nxt = `SACS_CODE_ZERO;
        if (acq_complete && strobe_rise) // RULE1
        begin
          state_nxt = sacs_pkg::ST_OPEN_SW;
          gnd_closed_nxt = 1'b0; // RULE3
          power_nxt = 1'b1;
        end
      end
      sacs_pkg::ST_OPEN_SW:
      begin
        if (tick)
        begin
          state_nxt = sacs_pkg::ST_GROUND;
          to_inputs_nxt = 1'b0; // RULE3 RULE5
        end
      end
      sacs_pkg::ST_GROUND:
      begin
        if (tick)
        begin
          state_nxt = sacs_pkg::ST_TRIAL;
          idx_nxt = 4'(`SACS_MSB_INDEX); // RULE4
          sar_nxt = bit_mask(4'(`SACS_MSB_INDEX)); // RULE14
        end
      end
      sacs_pkg::ST_TRIAL:
      begin
        if (tick)
        begin
          if (!COMP_KEEP)
          begin
            sar_nxt = sar_r & ~bit_mask(idx_r); // RULE14
          end
          if (idx_r == 4'h0)
          begin
            state_nxt = sacs_pkg::ST_FINISH;
          end
          else
          begin
            idx_nxt = idx_r - 4'h1; // RULE4
            sar_nxt = sar_nxt | bit_mask(idx_r - 4'h1); // RULE14
          end
        end
      end
      sacs_pkg::ST_FINISH:
      begin
        result_nxt = sar_r; // RULE8 RULE9 RULE10 RULE11
        done_nxt = 1'b1; // RULE6
        power_nxt = 1'b0; // RULE6 RULE12
        gnd_closed_nxt = 1'b1; // RULE6
        to_inputs_nxt = 1'b1;
        acq_cnt_nxt = '0;
        state_nxt = sacs_pkg::ST_ACQUIRE; // RULE13
      end
      default:
      begin
        state_nxt = sacs_pkg::ST_ACQUIRE;
        power_nxt = 1'b0;
        acq_cnt_nxt = '0;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_N)
    begin
      state_r <= sacs_pkg::ST_ACQUIRE;
      idx_r <= 4'h0;
      sar_r <= `SACS_CODE_ZERO;
      result_r <= `SACS_CODE_ZERO;
      acq_cnt_r <= '0;
      gnd_closed_r <= 1'b1;
      to_inputs_r <= 1'b1;
      power_r <= 1'b0;
      done_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      idx_r <= idx_nxt;
      sar_r <= sar_nxt;
      result_r <= result_nxt;
      acq_cnt_r <= acq_cnt_nxt;
      gnd_closed_r <= gnd_closed_nxt;
      to_inputs_r <= to_inputs_nxt;
      power_r <= power_nxt;
      done_r <= done_nxt;
    end
  end

  // Strobe edge detector
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_N)
    begin
      strobe_d_r <= 1'b0;
    end
    else
    begin
      strobe_d_r <= CONVERT_STROBE;
    end
  end

  // Outputs
  always_comb
  begin
    DAC_CTRL.pos_comparator_ground_switch = gnd_closed_r;
    DAC_CTRL.neg_comparator_ground_switch = gnd_closed_r;
    DAC_CTRL.arrays_to_inputs = to_inputs_r;
    DAC_CTRL.element_to_ref = sar_r;
    STATUS.busy = (state_r != sacs_pkg::ST_ACQUIRE);
    STATUS.acquiring = (state_r == sacs_pkg::ST_ACQUIRE);
    STATUS.core_powered = power_r;
    STATUS.done = done_r;
  end

  assign RESULT = result_r;

endmodule
`default_nettype wire

// >>> dv/sacs_seq_asserts.sv
// Port checker for the conversion sequencer
`timescale 1ns/100ps
`default_nettype none
module sacs_seq_asserts
(
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic CONVERT_STROBE,
  input wire logic COMP_KEEP,
  input wire sacs_pkg::sacs_dac_ctrl_t DAC_CTRL,
  input wire sacs_pkg::sacs_status_t STATUS,
  input wire logic [15:0] RESULT
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  acq_ground_a: assert property (STATUS.acquiring |->
    DAC_CTRL.pos_comparator_ground_switch &&
    DAC_CTRL.neg_comparator_ground_switch && DAC_CTRL.arrays_to_inputs)
    else $error("array not in acquisition setup");
  open_first_a: assert property ($fell(DAC_CTRL.arrays_to_inputs) |->
    !DAC_CTRL.neg_comparator_ground_switch &&
    !$past(DAC_CTRL.pos_comparator_ground_switch))
    else $error("arrays grounded before switches opened");
  start_a: assert property ($rose(STATUS.busy) |->
    $past(CONVERT_STROBE) && !$past(CONVERT_STROBE, 2))
    else $error("conversion without strobe rise");
  msb_first_a: assert property ($fell(DAC_CTRL.arrays_to_inputs) |->
    ##[1:8] DAC_CTRL.element_to_ref == 16'h8000)
    else $error("first trial not on top element");
  trial_span_a: assert property ($rose(STATUS.busy) |->
    ##[88:92] STATUS.done) else $error("conversion length wrong");
  done_power_a: assert property (STATUS.done |->
    !STATUS.core_powered ##1 STATUS.acquiring)
    else $error("no power down after last trial");
  result_hold_a: assert property ($changed(RESULT) |-> STATUS.done)
    else $error("result moved without completion");
  busy_end_a: assert property ($fell(STATUS.busy) |->
    STATUS.done || $past(STATUS.done)) else $error("conversion cut short");
  cover property ($rose(STATUS.busy));
  cover property (STATUS.done && RESULT == 16'hFFFF);
  cover property (STATUS.done && RESULT == 16'h0000);
endmodule
bind sacs_sequencer sacs_seq_asserts chk_u (.CLK_SYS(CLK_SYS),
  .RST_N(RST_N), .CONVERT_STROBE(CONVERT_STROBE), .COMP_KEEP(COMP_KEEP),
  .DAC_CTRL(DAC_CTRL), .STATUS(STATUS), .RESULT(RESULT));
`default_nettype wire

// >>> dv/sacs_cdac_model.sv
// Sampling array and comparator model at the far side
`timescale 1ns/100ps
`default_nettype none
module sacs_cdac_model
(
  input wire logic clk,
  input wire sacs_pkg::sacs_dac_ctrl_t dac,
  input wire logic signed [31:0] vin,
  output logic keep
);
  logic signed [31:0] held_r = 0;
  logic flip_r = 1'b0;
  always_ff @(posedge clk)
  begin
    flip_r <= !flip_r;
    if (dac.arrays_to_inputs)
      held_r <= vin;
  end
  // Meaningless output while tracking
  assign keep = dac.arrays_to_inputs ? flip_r :
    (held_r >= $signed({16'h0000, dac.element_to_ref}));
endmodule
`default_nettype wire

// >>> dv/tb_top.sv
// Self-checking bench for the conversion sequencer
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic CLK_SYS = 1'b0;
  logic RST_N = 1'b0;
  logic CONVERT_STROBE = 1'b0;
  logic COMP_KEEP;
  sacs_pkg::sacs_dac_ctrl_t DAC_CTRL;
  sacs_pkg::sacs_status_t STATUS;
  logic [15:0] RESULT;
  logic signed [31:0] vin = 0;
  logic [31:0] seed = 32'h0CB1E29B;
  logic [15:0] exp_q[$];
  int n_errors = 0;
  int checks_done = 0;
  int cyc = 0;
  int vals[7] = '{0, 32'h8000, 32'hFFFF, 32'h7FFF, 1, 70000, -5};
  initial forever #5 CLK_SYS = ~CLK_SYS;
  sacs_sequencer dut_u (.CLK_SYS(CLK_SYS), .RST_N(RST_N),
    .CONVERT_STROBE(CONVERT_STROBE), .COMP_KEEP(COMP_KEEP),
    .DAC_CTRL(DAC_CTRL), .STATUS(STATUS), .RESULT(RESULT));
  sacs_cdac_model cdac_u (.clk(CLK_SYS), .dac(DAC_CTRL), .vin(vin),
    .keep(COMP_KEEP));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] want,
    input string what);
    checks_done++;
    if (seen !== want)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic summarize();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Input held until arrays leave it, then disturbed with strobe noise
  task automatic convert(input int v);
    vin <= v;
    exp_q.push_back(v < 0 ? 16'h0000 : v > 65535 ? 16'hFFFF : v[15:0]);
    @(posedge CLK_SYS);
    CONVERT_STROBE <= 1'b1;
    repeat (10) @(posedge CLK_SYS);
    repeat (30)
    begin
      @(posedge CLK_SYS);
      seed = xs(seed);
      vin <= $signed(seed);
      CONVERT_STROBE <= seed[3];
    end
    @(posedge CLK_SYS);
    CONVERT_STROBE <= 1'b0;
    repeat (360) @(posedge CLK_SYS);
  endtask
  always @(posedge CLK_SYS)
  begin
    cyc <= cyc + 1;
    if (cyc == 8000)
    begin
      n_errors++;
      summarize();
    end
    else if (RST_N && STATUS.done === 1'b1)
    begin
      if (exp_q.size() == 0)
      begin
        n_errors++;
        $display("BAD result expected none seen %h", RESULT);
      end
      else
        check(RESULT, exp_q.pop_front(), "result");
    end
  end
  initial
  begin
    repeat (2) @(posedge CLK_SYS);
    RST_N <= 1'b1;
    repeat (20) @(posedge CLK_SYS);
    CONVERT_STROBE <= 1'b1;
    repeat (5) @(posedge CLK_SYS);
    check({15'h0000, STATUS.busy}, 16'h0000, "busy");
    CONVERT_STROBE <= 1'b0;
    repeat (170) @(posedge CLK_SYS);
    foreach (vals[i])
      convert(vals[i]);
    repeat (4)
    begin
      seed = xs(seed);
      convert({16'h0000, seed[15:0]});
    end
    check({15'h0000, exp_q.size() == 0}, 16'h0001, "pending");
    summarize();
  end
endmodule
`default_nettype wire
